// [core/eag_pkg.sv]
// eag_pkg: constants and types for the effective address generator
// assumes: a 32-bit core with sixteen general registers
`default_nettype none

package eag_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned GPR_N  = 16;
  localparam int unsigned WRAP_W = 16;

  // general register roles
  localparam logic [3:0] GPR_SINGLE_BASE = 4'h2;
  localparam logic [3:0] GPR_X_BASE      = 4'h4;
  localparam logic [3:0] GPR_Y_BASE      = 4'h6;
  localparam logic [3:0] GPR_XS_STEP     = 4'h8;
  localparam logic [3:0] GPR_Y_STEP      = 4'h9;

  // access size steps
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [31:0] LONG_PC_MASK = 32'hffff_fffc;

  // displacement scale shifts
  localparam int unsigned SHIFT_WORD = 1;
  localparam int unsigned SHIFT_LONG = 2;

  typedef enum logic [3:0] {
    MODE_REG_DIRECT,
    MODE_REG_INDIRECT,
    MODE_POST_INC,
    MODE_PRE_DEC,
    MODE_PC_DISP,
    MODE_PC_REL8,
    MODE_PC_REL12,
    MODE_XY_MOVE,
    MODE_SINGLE_MOVE
  } eag_mode_e;

  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_LONG
  } eag_size_e;

  typedef enum logic [1:0] {
    XY_KEEP,
    XY_INC,
    XY_ADD_STEP
  } eag_xy_upd_e;

  typedef enum logic [1:0] {
    SGL_KEEP,
    SGL_INC,
    SGL_ADD_STEP,
    SGL_DEC
  } eag_sgl_upd_e;

endpackage : eag_pkg

`default_nettype wire

// [core/eag_core.sv]
// eag_core: effective address generator of the integer and dsp pipelines
// assumes: decode presents one operation per valid cycle with a full register
// file view; results are registered and appear together one cycle later
`default_nettype none

module eag_core #(
  parameter int unsigned ADDR_W = eag_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                        I_CLK,
  input  wire logic                        I_RST_N,
  // decoded operation
  input  wire logic                        I_VALID,
  input  wire eag_pkg::eag_mode_e          I_MODE,
  input  wire eag_pkg::eag_size_e          I_SIZE,
  input  wire logic [3:0]                  I_REG_SEL,
  input  wire logic [11:0]                 I_DISP,
  input  wire logic                        I_X_SEL,
  input  wire logic                        I_Y_SEL,
  input  wire eag_pkg::eag_xy_upd_e        I_X_UPD,
  input  wire eag_pkg::eag_xy_upd_e        I_Y_UPD,
  input  wire logic [1:0]                  I_SINGLE_SEL,
  input  wire eag_pkg::eag_sgl_upd_e       I_SINGLE_UPD,
  // register file and program counter
  input  wire logic [15:0][ADDR_W-1:0]     I_GPR,
  input  wire logic [ADDR_W-1:0]           I_PC,
  // wrap control
  input  wire logic [15:0]                 I_WRAP_START_VALUE,
  input  wire logic [15:0]                 I_WRAP_END_VALUE,
  input  wire logic                        I_X_WRAP_ENABLE,
  input  wire logic                        I_Y_WRAP_ENABLE,
  // main access and operand
  output var  logic                        O_ACCESS_VALID,
  output var  logic [ADDR_W-1:0]           O_EA,
  output var  logic                        O_OPERAND_VALID,
  output var  logic [ADDR_W-1:0]           O_OPERAND,
  output var  logic                        O_ANY_SPACE,
  // main write-back
  output var  logic                        O_WB_EN,
  output var  logic [3:0]                  O_WB_IDX,
  output var  logic [ADDR_W-1:0]           O_WB_VAL,
  // dual x/y access
  output var  logic                        O_XY_VALID,
  output var  logic [ADDR_W-1:0]           O_X_ADDR,
  output var  logic [ADDR_W-1:0]           O_Y_ADDR,
  output var  logic                        O_X_WB_EN,
  output var  logic [3:0]                  O_X_WB_IDX,
  output var  logic [ADDR_W-1:0]           O_X_WB_VAL,
  output var  logic                        O_Y_WB_EN,
  output var  logic [3:0]                  O_Y_WB_IDX,
  output var  logic [ADDR_W-1:0]           O_Y_WB_VAL
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] size_step(input eag_pkg::eag_size_e sz);
    unique case (sz)
      eag_pkg::SIZE_BYTE: size_step = eag_pkg::STEP_BYTE;
      eag_pkg::SIZE_WORD: size_step = eag_pkg::STEP_WORD;
      eag_pkg::SIZE_LONG: size_step = eag_pkg::STEP_LONG;
      default:            size_step = eag_pkg::STEP_BYTE;
    endcase
  endfunction : size_step

  // low half jumps to start when it sits on the end value; index steps can
  // skip over the end value and then never wrap
  function automatic logic [ADDR_W-1:0] wrap_update(input logic [ADDR_W-1:0] ptr,
                                                    input logic [ADDR_W-1:0] step,
                                                    input logic [15:0]       wstart,
                                                    input logic [15:0]       wend);
    if (ptr[eag_pkg::WRAP_W-1:0] == wend) begin
      wrap_update = {ptr[ADDR_W-1:eag_pkg::WRAP_W], wstart};
    end else begin
      wrap_update = ptr + step;
    end
  endfunction : wrap_update

  // ----------------------------------------------------------------------
  // general addressing
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0] rn;
  logic [ADDR_W-1:0] step;
  logic [ADDR_W-1:0] disp_zx;
  logic [ADDR_W-1:0] disp8_sx;
  logic [ADDR_W-1:0] disp12_sx;
  logic [ADDR_W-1:0] pc_disp_ea;

  assign rn        = I_GPR[I_REG_SEL];
  assign step      = size_step(I_SIZE);
  assign disp_zx   = {{(ADDR_W-8){1'b0}}, I_DISP[7:0]};
  assign disp8_sx  = {{(ADDR_W-8){I_DISP[7]}}, I_DISP[7:0]};
  assign disp12_sx = {{(ADDR_W-12){I_DISP[11]}}, I_DISP};

  always_comb begin
    unique case (I_SIZE)
      eag_pkg::SIZE_BYTE: pc_disp_ea = I_PC + disp_zx;
      eag_pkg::SIZE_WORD: pc_disp_ea = I_PC + (disp_zx << eag_pkg::SHIFT_WORD);
      eag_pkg::SIZE_LONG: pc_disp_ea = (I_PC & eag_pkg::LONG_PC_MASK)
                                       + (disp_zx << eag_pkg::SHIFT_LONG);
      default:            pc_disp_ea = I_PC + disp_zx;
    endcase
  end

  // ----------------------------------------------------------------------
  // dsp pointers
  // ----------------------------------------------------------------------
  logic [3:0]        x_idx;
  logic [3:0]        y_idx;
  logic [3:0]        s_idx;
  logic [ADDR_W-1:0] x_memory_pointer;
  logic [ADDR_W-1:0] y_memory_pointer;
  logic [ADDR_W-1:0] single_transfer_pointer;
  logic [ADDR_W-1:0] x_pointer_step;
  logic [ADDR_W-1:0] y_pointer_step;
  logic [ADDR_W-1:0] single_transfer_step;
  logic              x_wrap_on;
  logic              y_wrap_on;
  logic [ADDR_W-1:0] x_add;
  logic [ADDR_W-1:0] y_add;
  logic [ADDR_W-1:0] x_next;
  logic [ADDR_W-1:0] y_next;
  logic [ADDR_W-1:0] s_step;
  logic [ADDR_W-1:0] s_dec;

  assign x_idx                   = eag_pkg::GPR_X_BASE | {3'h0, I_X_SEL};
  assign y_idx                   = eag_pkg::GPR_Y_BASE | {3'h0, I_Y_SEL};
  assign s_idx                   = eag_pkg::GPR_SINGLE_BASE + {2'h0, I_SINGLE_SEL};
  assign x_memory_pointer        = I_GPR[x_idx];
  assign y_memory_pointer        = I_GPR[y_idx];
  assign single_transfer_pointer = I_GPR[s_idx];
  assign x_pointer_step          = I_GPR[eag_pkg::GPR_XS_STEP];
  assign y_pointer_step          = I_GPR[eag_pkg::GPR_Y_STEP];
  assign single_transfer_step    = I_GPR[eag_pkg::GPR_XS_STEP];
  // only one pointer may wrap; the y enable wins when both are set
  assign y_wrap_on               = I_Y_WRAP_ENABLE;
  assign x_wrap_on               = I_X_WRAP_ENABLE && !I_Y_WRAP_ENABLE;

  // a minus-two step decrements a dual pointer; no decrement mode exists
  always_comb begin
    unique case (I_X_UPD)
      eag_pkg::XY_KEEP:     x_add = '0;
      eag_pkg::XY_INC:      x_add = eag_pkg::STEP_WORD;
      eag_pkg::XY_ADD_STEP: x_add = x_pointer_step;
      default:              x_add = '0;
    endcase
    unique case (I_Y_UPD)
      eag_pkg::XY_KEEP:     y_add = '0;
      eag_pkg::XY_INC:      y_add = eag_pkg::STEP_WORD;
      eag_pkg::XY_ADD_STEP: y_add = y_pointer_step;
      default:              y_add = '0;
    endcase
  end

  always_comb begin
    if (x_wrap_on && I_X_UPD != eag_pkg::XY_KEEP) begin
      x_next = wrap_update(x_memory_pointer, x_add, I_WRAP_START_VALUE, I_WRAP_END_VALUE);
    end else begin
      x_next = x_memory_pointer + x_add;
    end
    if (y_wrap_on && I_Y_UPD != eag_pkg::XY_KEEP) begin
      y_next = wrap_update(y_memory_pointer, y_add, I_WRAP_START_VALUE, I_WRAP_END_VALUE);
    end else begin
      y_next = y_memory_pointer + y_add;
    end
  end

  // single transfers move words or longwords only
  assign s_step = (I_SIZE == eag_pkg::SIZE_LONG) ? eag_pkg::STEP_LONG : eag_pkg::STEP_WORD;
  assign s_dec  = single_transfer_pointer - s_step;

  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------
  logic              acc_nxt;
  logic [ADDR_W-1:0] ea_nxt;
  logic              opv_nxt;
  logic [ADDR_W-1:0] op_nxt;
  logic              any_nxt;
  logic              wb_en_nxt;
  logic [3:0]        wb_idx_nxt;
  logic [ADDR_W-1:0] wb_val_nxt;
  logic              xy_nxt;

  always_comb begin
    acc_nxt    = 1'b0;
    ea_nxt     = '0;
    opv_nxt    = 1'b0;
    op_nxt     = '0;
    any_nxt    = 1'b0;
    wb_en_nxt  = 1'b0;
    wb_idx_nxt = I_REG_SEL;
    wb_val_nxt = '0;
    xy_nxt     = 1'b0;
    if (I_VALID) begin
      unique case (I_MODE)
        eag_pkg::MODE_REG_DIRECT: begin
          opv_nxt = 1'b1;
          op_nxt  = rn;
        end
        eag_pkg::MODE_REG_INDIRECT: begin
          acc_nxt = 1'b1;
          ea_nxt  = rn;
          any_nxt = 1'b1;
        end
        eag_pkg::MODE_POST_INC: begin
          acc_nxt    = 1'b1;
          ea_nxt     = rn;
          any_nxt    = 1'b1;
          wb_en_nxt  = 1'b1;
          wb_val_nxt = rn + step;
        end
        eag_pkg::MODE_PRE_DEC: begin
          acc_nxt    = 1'b1;
          ea_nxt     = rn - step;
          any_nxt    = 1'b1;
          wb_en_nxt  = 1'b1;
          wb_val_nxt = rn - step;
        end
        eag_pkg::MODE_PC_DISP: begin
          acc_nxt = 1'b1;
          ea_nxt  = pc_disp_ea;
          any_nxt = 1'b1;
        end
        eag_pkg::MODE_PC_REL8: begin
          opv_nxt = 1'b1;
          op_nxt  = I_PC + (disp8_sx << eag_pkg::SHIFT_WORD);
        end
        eag_pkg::MODE_PC_REL12: begin
          opv_nxt = 1'b1;
          op_nxt  = I_PC + (disp12_sx << eag_pkg::SHIFT_WORD);
        end
        eag_pkg::MODE_XY_MOVE: begin
          xy_nxt = 1'b1;
        end
        eag_pkg::MODE_SINGLE_MOVE: begin
          // address always comes from a pointer register
          acc_nxt    = 1'b1;
          any_nxt    = 1'b1;
          wb_idx_nxt = s_idx;
          unique case (I_SINGLE_UPD)
            eag_pkg::SGL_KEEP: begin
              ea_nxt = single_transfer_pointer;
            end
            eag_pkg::SGL_INC: begin
              ea_nxt     = single_transfer_pointer;
              wb_en_nxt  = 1'b1;
              wb_val_nxt = single_transfer_pointer + s_step;
            end
            eag_pkg::SGL_ADD_STEP: begin
              ea_nxt     = single_transfer_pointer;
              wb_en_nxt  = 1'b1;
              wb_val_nxt = single_transfer_pointer + single_transfer_step;
            end
            eag_pkg::SGL_DEC: begin
              ea_nxt     = s_dec;
              wb_en_nxt  = 1'b1;
              wb_val_nxt = s_dec;
            end
            default: begin
              ea_nxt = single_transfer_pointer;
            end
          endcase
        end
        default: begin
          acc_nxt = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_ACCESS_VALID  <= 1'b0;
      O_EA            <= '0;
      O_OPERAND_VALID <= 1'b0;
      O_OPERAND       <= '0;
      O_ANY_SPACE     <= 1'b0;
    end else begin
      O_ACCESS_VALID  <= acc_nxt;
      O_EA            <= ea_nxt;
      O_OPERAND_VALID <= opv_nxt;
      O_OPERAND       <= op_nxt;
      O_ANY_SPACE     <= any_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_EN  <= 1'b0;
      O_WB_IDX <= '0;
      O_WB_VAL <= '0;
    end else begin
      O_WB_EN  <= wb_en_nxt;
      O_WB_IDX <= wb_idx_nxt;
      O_WB_VAL <= wb_val_nxt;
    end
  end

  // both pointers leave in the same cycle as the pre-update addresses
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_XY_VALID <= 1'b0;
      O_X_ADDR   <= '0;
      O_Y_ADDR   <= '0;
      O_X_WB_EN  <= 1'b0;
      O_X_WB_IDX <= '0;
      O_X_WB_VAL <= '0;
      O_Y_WB_EN  <= 1'b0;
      O_Y_WB_IDX <= '0;
      O_Y_WB_VAL <= '0;
    end else begin
      O_XY_VALID <= xy_nxt;
      O_X_ADDR   <= xy_nxt ? x_memory_pointer : '0;
      O_Y_ADDR   <= xy_nxt ? y_memory_pointer : '0;
      O_X_WB_EN  <= xy_nxt && (I_X_UPD != eag_pkg::XY_KEEP);
      O_X_WB_IDX <= x_idx;
      O_X_WB_VAL <= x_next;
      O_Y_WB_EN  <= xy_nxt && (I_Y_UPD != eag_pkg::XY_KEEP);
      O_Y_WB_IDX <= y_idx;
      O_Y_WB_VAL <= y_next;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  direct_no_access_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_VALID && I_MODE == eag_pkg::MODE_REG_DIRECT |=> O_OPERAND == $past(rn) && !O_ACCESS_VALID)
    else $error("register direct operand wrong or access raised");

  indirect_ea_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_VALID && I_MODE == eag_pkg::MODE_REG_INDIRECT |=> O_EA == $past(rn) && !O_WB_EN)
    else $error("indirect address differs from register");

  post_inc_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_VALID && I_MODE == eag_pkg::MODE_POST_INC && I_SIZE == eag_pkg::SIZE_LONG
    |=> O_EA == $past(rn) && O_WB_VAL == $past(rn) + 32'h0000_0004)
    else $error("post increment longword wrong");

  pre_dec_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_VALID && I_MODE == eag_pkg::MODE_PRE_DEC && I_SIZE == eag_pkg::SIZE_BYTE
    |=> O_EA == $past(rn) - 32'h0000_0001 && O_WB_VAL == O_EA)
    else $error("pre decrement byte wrong");

  pc_long_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_VALID && I_MODE == eag_pkg::MODE_PC_DISP && I_SIZE == eag_pkg::SIZE_LONG
    |=> O_EA[1:0] == 2'h0 && O_EA == {$past(I_PC[31:2]), 2'h0} + {22'h0, $past(I_DISP[7:0]), 2'h0})
    else $error("longword pc displacement wrong");

  branch_short_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_VALID && I_MODE == eag_pkg::MODE_PC_REL8
    |=> O_OPERAND == $past(I_PC) + {{23{$past(I_DISP[7])}}, $past(I_DISP[7:0]), 1'b0})
    else $error("short branch target wrong");

  xy_pair_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_VALID && I_MODE == eag_pkg::MODE_XY_MOVE
    |=> O_XY_VALID && !O_ACCESS_VALID && O_X_WB_IDX[3:1] == 3'h2 && O_Y_WB_IDX[3:1] == 3'h3)
    else $error("dual transfer pointers not paired");

  xy_inc_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_XY_VALID && O_X_WB_EN && O_X_ADDR[15:0] != $past(I_WRAP_END_VALUE)
    && $past(I_X_UPD) == eag_pkg::XY_INC |-> O_X_WB_VAL == O_X_ADDR + 32'h0000_0002)
    else $error("x pointer increment wrong");

  wrap_hit_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_Y_WB_EN && $past(I_Y_WRAP_ENABLE) && O_Y_ADDR[15:0] == $past(I_WRAP_END_VALUE)
    |-> O_Y_WB_VAL == {O_Y_ADDR[31:16], $past(I_WRAP_START_VALUE)})
    else $error("y pointer did not wrap");

  single_dec_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_VALID && I_MODE == eag_pkg::MODE_SINGLE_MOVE && I_SINGLE_UPD == eag_pkg::SGL_DEC
    ##1 O_ACCESS_VALID |-> O_EA == O_WB_VAL && O_WB_IDX >= 4'h2 && O_WB_IDX <= 4'h5)
    else $error("single pre decrement wrong");

endmodule : eag_core

`default_nettype wire

// [verif/eag_pipe_model.sv]
// eag_pipe_model: register file and write-back side of the pipeline
// assumes: bench preloads registers; design write-backs land on the next edge
`default_nettype none

module eag_pipe_model (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // bench preload
  input  wire logic              i_ld_en,
  input  wire logic [3:0]        i_ld_idx,
  input  wire logic [31:0]       i_ld_val,
  // design write-backs
  input  wire logic              i_wb_en,
  input  wire logic [3:0]        i_wb_idx,
  input  wire logic [31:0]       i_wb_val,
  input  wire logic              i_x_wb_en,
  input  wire logic [3:0]        i_x_wb_idx,
  input  wire logic [31:0]       i_x_wb_val,
  input  wire logic              i_y_wb_en,
  input  wire logic [3:0]        i_y_wb_idx,
  input  wire logic [31:0]       i_y_wb_val,
  // register file view
  output logic [15:0][31:0]      o_gpr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0][31:0] gpr_r;

  // -------------------------------------------------
  // register file: preload, then pointer write-backs
  // -------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gpr_r <= '0;
    end else begin
      if (i_ld_en) begin
        gpr_r[i_ld_idx] <= i_ld_val;
      end
      if (i_wb_en) begin
        gpr_r[i_wb_idx] <= i_wb_val;
      end
      if (i_x_wb_en) begin
        gpr_r[i_x_wb_idx] <= i_x_wb_val;
      end
      if (i_y_wb_en) begin
        gpr_r[i_y_wb_idx] <= i_y_wb_val;
      end
    end
  end

  assign o_gpr = gpr_r;
endmodule : eag_pipe_model

`default_nettype wire

// [verif/effective_address_generator_test.sv]
// effective_address_generator_test: directed scenarios for eag_core
// assumes: eag_pipe_model feeds the register file and absorbs write-backs
`default_nettype none

module effective_address_generator_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, x_sel = 1'b0, y_sel = 1'b0;
  logic x_wrap = 1'b0, y_wrap = 1'b0, ld_en = 1'b0;
  eag_pkg::eag_mode_e    mode  = eag_pkg::MODE_REG_DIRECT;
  eag_pkg::eag_size_e    size  = eag_pkg::SIZE_BYTE;
  eag_pkg::eag_xy_upd_e  x_upd = eag_pkg::XY_KEEP;
  eag_pkg::eag_xy_upd_e  y_upd = eag_pkg::XY_KEEP;
  eag_pkg::eag_sgl_upd_e s_upd = eag_pkg::SGL_KEEP;
  logic [3:0]  reg_sel = 4'h0, ld_idx = 4'h0;
  logic [11:0] disp = 12'h000;
  logic [1:0]  s_sel = 2'h0;
  logic [31:0] pc = 32'h0, ld_val = 32'h0;
  logic [15:0] w_start = 16'h0, w_end = 16'h0;
  logic [15:0][31:0] gpr;
  logic acc_v, op_v, any_sp, wb_en, xy_v, x_wb_en, y_wb_en;
  logic [3:0] wb_idx, x_wb_idx, y_wb_idx;
  logic [31:0] ea, operand, wb_val, x_addr, y_addr, x_wb_val, y_wb_val;
  int miscompares = 0;
  int n_checks = 0;

  always #12.5 clk = ~clk;

  eag_core dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_VALID(valid), .I_MODE(mode), .I_SIZE(size),
    .I_REG_SEL(reg_sel), .I_DISP(disp), .I_X_SEL(x_sel), .I_Y_SEL(y_sel), .I_X_UPD(x_upd),
    .I_Y_UPD(y_upd), .I_SINGLE_SEL(s_sel), .I_SINGLE_UPD(s_upd), .I_GPR(gpr), .I_PC(pc),
    .I_WRAP_START_VALUE(w_start), .I_WRAP_END_VALUE(w_end), .I_X_WRAP_ENABLE(x_wrap),
    .I_Y_WRAP_ENABLE(y_wrap), .O_ACCESS_VALID(acc_v), .O_EA(ea), .O_OPERAND_VALID(op_v),
    .O_OPERAND(operand), .O_ANY_SPACE(any_sp), .O_WB_EN(wb_en), .O_WB_IDX(wb_idx),
    .O_WB_VAL(wb_val), .O_XY_VALID(xy_v), .O_X_ADDR(x_addr), .O_Y_ADDR(y_addr),
    .O_X_WB_EN(x_wb_en), .O_X_WB_IDX(x_wb_idx), .O_X_WB_VAL(x_wb_val), .O_Y_WB_EN(y_wb_en),
    .O_Y_WB_IDX(y_wb_idx), .O_Y_WB_VAL(y_wb_val));

  eag_pipe_model model (
    .i_clk(clk), .i_rst_n(rst_n), .i_ld_en(ld_en), .i_ld_idx(ld_idx), .i_ld_val(ld_val),
    .i_wb_en(wb_en), .i_wb_idx(wb_idx), .i_wb_val(wb_val), .i_x_wb_en(x_wb_en),
    .i_x_wb_idx(x_wb_idx), .i_x_wb_val(x_wb_val), .i_y_wb_en(y_wb_en),
    .i_y_wb_idx(y_wb_idx), .i_y_wb_val(y_wb_val), .o_gpr(gpr));

  // -------------------------------------------------
  // shared drivers and comparison
  // -------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // wide enough for index, enable and value packed together
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic ld(input logic [3:0] i, input logic [31:0] v);
    @(posedge clk);
    ld_en <= 1'b1;
    ld_idx <= i;
    ld_val <= v;
    @(posedge clk);
    ld_en <= 1'b0;
  endtask : ld

  // one request; returns in the cycle its registered answer stands
  task automatic op(input eag_pkg::eag_mode_e m, input int s, input logic [3:0] r, input logic [11:0] d);
    @(posedge clk);
    valid <= 1'b1;
    mode <= m;
    size <= eag_pkg::eag_size_e'(s);
    reg_sel <= r;
    disp <= d;
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
  endtask : op

  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic t_general();
    logic [31:0] a;
    ld(4'h1, 32'h1234_abcd);
    op(eag_pkg::MODE_REG_DIRECT, 2, 4'h1, 12'h0);
    chk(operand, 32'h1234_abcd);
    chk({wb_en, acc_v, op_v}, 32'h1);
    ld(4'h3, 32'h8000_0001);
    op(eag_pkg::MODE_REG_INDIRECT, 1, 4'h3, 12'h0);
    chk(ea, 32'h8000_0001);
    chk({wb_en, acc_v, any_sp}, 32'h3);
    a = 32'hffff_fffd;
    ld(4'h3, a);
    for (int k = 0; k < 3; k++) begin
      op(eag_pkg::MODE_POST_INC, k, 4'h3, 12'h0);
      chk(ea, a);
      a = a + (32'h1 << k);
      chk({wb_idx, wb_val}, {4'h3, a});
    end
    a = 32'h0000_0003;
    ld(4'h2, a);
    for (int k = 0; k < 3; k++) begin
      op(eag_pkg::MODE_PRE_DEC, k, 4'h2, 12'h0);
      a = a - (32'h1 << k);
      chk(ea, a);
      chk({wb_en, wb_val}, {1'b1, a});
    end
  endtask : t_general

  task automatic t_pc();
    logic [31:0] e [3] = '{32'h1102, 32'h1201, 32'h13fc};
    logic [31:0] b [4] = '{32'h0f03, 32'h1101, 32'h0003, 32'h2001};
    logic [11:0] d [4] = '{12'h080, 12'hf7f, 12'h800, 12'h7ff};
    @(posedge clk);
    pc <= 32'h0000_1003;
    for (int k = 0; k < 3; k++) begin
      op(eag_pkg::MODE_PC_DISP, k, 4'h0, 12'hfff);
      chk(ea, e[k]);
    end
    for (int k = 0; k < 4; k++) begin
      op(k < 2 ? eag_pkg::MODE_PC_REL8 : eag_pkg::MODE_PC_REL12, 1, 4'h0, d[k]);
      chk(operand, b[k]);
      chk({acc_v, op_v}, 32'h1);
    end
  endtask : t_pc

  task automatic t_xy();
    ld(4'h4, 32'h0000_0100);
    ld(4'h5, 32'h2000_0000);
    ld(4'h6, 32'h0000_0300);
    ld(4'h7, 32'h0000_0400);
    ld(4'h8, 32'hffff_fffe);
    ld(4'h9, 32'h0000_0010);
    @(posedge clk);
    x_sel <= 1'b1;
    x_upd <= eag_pkg::XY_ADD_STEP;
    y_upd <= eag_pkg::XY_INC;
    op(eag_pkg::MODE_XY_MOVE, 1, 4'h0, 12'h0);
    chk(x_addr, 32'h2000_0000);
    chk(y_addr, 32'h0000_0300);
    chk(x_wb_val, 32'h1fff_fffe);
    chk(y_wb_val, 32'h0000_0302);
    chk({x_wb_idx, y_wb_idx, x_wb_en, y_wb_en, xy_v, acc_v}, 32'h05_6e);
    @(posedge clk);
    x_sel <= 1'b0;
    y_sel <= 1'b1;
    x_upd <= eag_pkg::XY_KEEP;
    y_upd <= eag_pkg::XY_ADD_STEP;
    op(eag_pkg::MODE_XY_MOVE, 1, 4'h0, 12'h0);
    chk({x_addr[15:0], y_addr[15:0]}, 32'h0100_0400);
    chk(y_wb_val, 32'h0000_0410);
    chk({y_wb_idx, x_wb_en, y_wb_en}, 32'h1d);
  endtask : t_xy

  task automatic t_wrap();
    logic [31:0] a = 32'h0000_c008;
    ld(4'h4, a);
    @(posedge clk);
    w_start <= 16'hc008;
    w_end <= 16'hc00c;
    x_wrap <= 1'b1;
    x_sel <= 1'b0;
    x_upd <= eag_pkg::XY_INC;
    y_upd <= eag_pkg::XY_KEEP;
    for (int k = 0; k < 4; k++) begin
      op(eag_pkg::MODE_XY_MOVE, 1, 4'h0, 12'h0);
      chk(x_addr, a);
      a = (a == 32'h0000_c00c) ? 32'h0000_c008 : a + 32'h2;
      chk(x_wb_val, a);
    end
    // both enables set: only y wraps, upper half kept
    ld(4'h4, 32'h0001_c00c);
    ld(4'h6, 32'h0002_c00c);
    @(posedge clk);
    y_wrap <= 1'b1;
    y_sel <= 1'b0;
    y_upd <= eag_pkg::XY_INC;
    op(eag_pkg::MODE_XY_MOVE, 1, 4'h0, 12'h0);
    chk(x_wb_val, 32'h0001_c00e);
    chk(y_wb_val, 32'h0002_c008);
  endtask : t_wrap

  task automatic t_single();
    eag_pkg::eag_sgl_upd_e u [6] = '{eag_pkg::SGL_DEC, eag_pkg::SGL_INC, eag_pkg::SGL_INC,
                                     eag_pkg::SGL_ADD_STEP, eag_pkg::SGL_KEEP, eag_pkg::SGL_DEC};
    int sz [6] = '{2, 1, 2, 1, 1, 1};
    logic [31:0] e [6] = '{32'h0ffc, 32'h0ffc, 32'h0ffe, 32'h1002, 32'h1042, 32'h1040};
    logic [31:0] w [6] = '{32'h0ffc, 32'h0ffe, 32'h1002, 32'h1042, 32'h1042, 32'h1040};
    ld(4'h5, 32'h0000_1000);
    ld(4'h8, 32'h0000_0040);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      s_sel <= 2'h3;
      s_upd <= u[k];
      op(eag_pkg::MODE_SINGLE_MOVE, sz[k], 4'h0, 12'h0);
      chk(ea, e[k]);
      chk({acc_v, any_sp, xy_v}, 32'h6);
      if (k != 4) begin
        chk({wb_en, wb_idx, wb_val}, {1'b1, 4'h5, w[k]});
      end else begin
        chk({31'h0, wb_en}, 32'h0);
      end
    end
  endtask : t_single

  // mid-run reset clears a pending answer; first request right after release
  task automatic t_reset();
    @(posedge clk);
    valid <= 1'b1;
    mode <= eag_pkg::MODE_PC_REL8;
    disp <= 12'h002;
    @(posedge clk);
    @(posedge clk);
    valid <= 1'b0;
    rst_n <= 1'b0;
    @(negedge clk);
    chk({acc_v, op_v, any_sp, wb_en, xy_v, x_wb_en, y_wb_en}, 32'h0);
    chk(operand | ea | wb_val | x_addr | y_addr | x_wb_val | y_wb_val, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    @(negedge clk);
    chk({op_v, operand}, {1'b1, 32'h0000_1007});
  endtask : t_reset

  // -------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_general();
    t_pc();
    t_xy();
    t_wrap();
    t_single();
    t_reset();
    end_of_test();
  end

  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule : effective_address_generator_test

`default_nettype wire
